// ### pmr_power_monitor_regs.sv
// Function
// - Bit 15 write: full reset, self-clears
// - Bit 14 write clears energy, charge
// - First conversion delayed by field times 2ms
// - Bit 5 enables sense resistor drift correction
// - Bit 4 selects narrower sense range
// - Control bits 3-0 always read zero
// - Reset gives setup FB68h, control zero
// - Pointer retained until next write changes it
// - Register bytes travel most significant first
`timescale 1ns/1ps
module pmr_power_monitor_regs #(
    parameter int DELAY_STEP_CYCLES = pmr_pkg::DELAY_STEP_CYCLES,
    parameter logic [15:0] MAKER_IDENTITY = pmr_pkg::MAKER_IDENTITY_VAL,
    parameter logic [15:0] PART_IDENTITY = pmr_pkg::PART_IDENTITY_VAL
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Two-wire link pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [3:0] addr_pin_code,
    // Measurement core results
    input wire logic [23:0] sense_voltage_meas,
    input wire logic [23:0] rail_voltage_meas,
    input wire logic [15:0] die_temperature_meas,
    input wire logic [23:0] current_meas,
    input wire logic [23:0] power_meas,
    input wire logic [15:0] diag_flags_meas,
    input wire logic acc_step,
    input wire logic [39:0] energy_step,
    input wire logic [39:0] charge_step,
    // Configuration towards the measurement core
    output logic sense_drift_correction,
    output logic sense_range_select,
    output logic conversion_enable,
    output logic [15:0] converter_setup,
    output logic [15:0] sense_resistor_scale,
    output logic [15:0] sense_resistor_drift_coeff,
    output logic [15:0] sense_over_threshold,
    output logic [15:0] sense_under_threshold,
    output logic [15:0] rail_over_threshold,
    output logic [15:0] rail_under_threshold,
    output logic [15:0] temperature_over_threshold,
    output logic [15:0] power_over_threshold
);

    pmr_pkg::pmr_state_t state_r;
    logic scl_q_r;
    logic sda_q_r;
    logic [6:0] dev_addr_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] rx_r;
    logic [7:0] ptr_r;
    logic [7:0] wr_hi_r;
    logic [1:0] wbyte_r;
    logic rw_r;
    logic host_ack_r;
    logic [pmr_pkg::SHIFT_W-1:0] tx_r;
    logic [pmr_pkg::SHIFT_W-1:0] rd_word;
    logic wr_en_r;
    logic [15:0] wr_data_r;
    logic soft_rst_r;
    logic [15:0] ctrl_r;
    logic [39:0] energy_r;
    logic [39:0] charge_r;
    logic [pmr_pkg::DELAY_CNT_W-1:0] dly_cnt_r;
    logic conv_en_r;
    logic [15:0] rw_q [pmr_pkg::NUM_RW];
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic ctrl_wr;

    assign scl_rise = scl_in & ~scl_q_r;
    assign scl_fall = ~scl_in & scl_q_r;
    assign start_cond = scl_in & scl_q_r & sda_q_r & ~sda_in;
    assign stop_cond = scl_in & scl_q_r & ~sda_q_r & sda_in;
    assign ctrl_wr = wr_en_r & (ptr_r == pmr_pkg::OFS_DEVICE_CONTROL);

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    always_comb begin
        case (state_r)
            pmr_pkg::PMR_ADDR_ACK,
            pmr_pkg::PMR_PTR_ACK,
            pmr_pkg::PMR_WDATA_ACK: sda_oe = 1'b1;
            pmr_pkg::PMR_RDATA: sda_oe = ~tx_r[pmr_pkg::SHIFT_W-1];
            default: sda_oe = 1'b0;
        endcase
    end

    // Line history and address straps, which may move after release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            dev_addr_r <= pmr_pkg::LINK_ADDR_BASE;
        end else begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
            dev_addr_r <= pmr_pkg::LINK_ADDR_BASE | {3'b000, addr_pin_code};
        end
    end

    // Read word, left aligned so the top byte goes out first
    always_comb begin
        case (ptr_r)
            pmr_pkg::OFS_DEVICE_CONTROL: rd_word = {ctrl_r & pmr_pkg::CTRL_STORE_MASK, 24'h00_0000};
            pmr_pkg::OFS_CONVERTER_SETUP: rd_word = {rw_q[0], 24'h00_0000};
            pmr_pkg::OFS_SENSE_RESISTOR_SCALE: rd_word = {rw_q[1], 24'h00_0000};
            pmr_pkg::OFS_SENSE_RESISTOR_DRIFT_COEFF: rd_word = {rw_q[2], 24'h00_0000};
            pmr_pkg::OFS_SENSE_VOLTAGE_RESULT: rd_word = {sense_voltage_meas, 16'h0000};
            pmr_pkg::OFS_RAIL_VOLTAGE_RESULT: rd_word = {rail_voltage_meas, 16'h0000};
            pmr_pkg::OFS_DIE_TEMPERATURE_RESULT: rd_word = {die_temperature_meas, 24'h00_0000};
            pmr_pkg::OFS_CURRENT_RESULT: rd_word = {current_meas, 16'h0000};
            pmr_pkg::OFS_POWER_RESULT: rd_word = {power_meas, 16'h0000};
            pmr_pkg::OFS_ENERGY_ACCUMULATOR: rd_word = energy_r;
            pmr_pkg::OFS_CHARGE_ACCUMULATOR: rd_word = charge_r;
            pmr_pkg::OFS_DIAGNOSTIC_FLAGS_ALERT: rd_word = {diag_flags_meas, 24'h00_0000};
            pmr_pkg::OFS_SENSE_OVER_THRESHOLD: rd_word = {rw_q[3], 24'h00_0000};
            pmr_pkg::OFS_SENSE_UNDER_THRESHOLD: rd_word = {rw_q[4], 24'h00_0000};
            pmr_pkg::OFS_RAIL_OVER_THRESHOLD: rd_word = {rw_q[5], 24'h00_0000};
            pmr_pkg::OFS_RAIL_UNDER_THRESHOLD: rd_word = {rw_q[6], 24'h00_0000};
            pmr_pkg::OFS_TEMPERATURE_OVER_THRESHOLD: rd_word = {rw_q[7], 24'h00_0000};
            pmr_pkg::OFS_POWER_OVER_THRESHOLD: rd_word = {rw_q[8], 24'h00_0000};
            pmr_pkg::OFS_MAKER_IDENTITY: rd_word = {MAKER_IDENTITY, 24'h00_0000};
            pmr_pkg::OFS_PART_IDENTITY: rd_word = {PART_IDENTITY, 24'h00_0000};
            default: rd_word = '0;
        endcase
    end

    // Link protocol engine
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= pmr_pkg::PMR_IDLE;
            bit_cnt_r <= 4'h0;
            rx_r <= 8'h00;
            ptr_r <= 8'h00;
            wr_hi_r <= 8'h00;
            wbyte_r <= 2'b00;
            rw_r <= 1'b0;
            host_ack_r <= 1'b0;
            tx_r <= '0;
            wr_en_r <= 1'b0;
            wr_data_r <= 16'h0000;
        end else begin
            wr_en_r <= 1'b0;
            if (soft_rst_r) begin
                ptr_r <= 8'h00;
            end
            if (stop_cond) begin
                state_r <= pmr_pkg::PMR_IDLE;
            end else if (start_cond) begin
                state_r <= pmr_pkg::PMR_ADDR;
                bit_cnt_r <= 4'h0;
            end else begin
                case (state_r)
                    pmr_pkg::PMR_ADDR,
                    pmr_pkg::PMR_PTR,
                    pmr_pkg::PMR_WDATA: begin
                        if (scl_rise) begin
                            rx_r <= {rx_r[6:0], sda_in};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == pmr_pkg::BITS_PER_BYTE) begin
                            bit_cnt_r <= 4'h0;
                            if (state_r == pmr_pkg::PMR_ADDR) begin
                                if (rx_r[7:1] == dev_addr_r) begin
                                    rw_r <= rx_r[0];
                                    tx_r <= rd_word;
                                    state_r <= pmr_pkg::PMR_ADDR_ACK;
                                end else begin
                                    state_r <= pmr_pkg::PMR_IDLE;
                                end
                            end else if (state_r == pmr_pkg::PMR_PTR) begin
                                ptr_r <= rx_r;
                                wbyte_r <= 2'b00;
                                state_r <= pmr_pkg::PMR_PTR_ACK;
                            end else begin
                                // High byte arrives first, commit on the low byte
                                if (wbyte_r == 2'b00) begin
                                    wr_hi_r <= rx_r;
                                end else if (wbyte_r == 2'b01) begin
                                    wr_en_r <= 1'b1;
                                    wr_data_r <= {wr_hi_r, rx_r};
                                end
                                if (wbyte_r != 2'b10) begin
                                    wbyte_r <= wbyte_r + 2'b01;
                                end
                                state_r <= pmr_pkg::PMR_WDATA_ACK;
                            end
                        end
                    end
                    pmr_pkg::PMR_ADDR_ACK: begin
                        if (scl_fall) begin
                            state_r <= rw_r ? pmr_pkg::PMR_RDATA : pmr_pkg::PMR_PTR;
                        end
                    end
                    pmr_pkg::PMR_PTR_ACK,
                    pmr_pkg::PMR_WDATA_ACK: begin
                        if (scl_fall) begin
                            state_r <= pmr_pkg::PMR_WDATA;
                        end
                    end
                    pmr_pkg::PMR_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            tx_r <= {tx_r[pmr_pkg::SHIFT_W-2:0], 1'b0};
                            if (bit_cnt_r == pmr_pkg::BITS_PER_BYTE) begin
                                bit_cnt_r <= 4'h0;
                                state_r <= pmr_pkg::PMR_RACK;
                            end
                        end
                    end
                    pmr_pkg::PMR_RACK: begin
                        if (scl_rise) begin
                            host_ack_r <= ~sda_in;
                        end else if (scl_fall) begin
                            state_r <= host_ack_r ? pmr_pkg::PMR_RDATA : pmr_pkg::PMR_IDLE;
                        end
                    end
                    pmr_pkg::PMR_IDLE: begin
                        bit_cnt_r <= 4'h0;
                    end
                    default: state_r <= pmr_pkg::PMR_IDLE;
                endcase
            end
        end
    end

    // Soft reset pulse; a write to bit 15 never lands in storage
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= ctrl_wr & wr_data_r[pmr_pkg::CTRL_SOFT_RESET_BIT];
        end
    end

    // Control register, only bits 13..4 are kept
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= pmr_pkg::CTRL_RESET;
        end else if (soft_rst_r) begin
            ctrl_r <= pmr_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_r <= wr_data_r & pmr_pkg::CTRL_STORE_MASK;
        end
    end

    assign sense_drift_correction = ctrl_r[pmr_pkg::CTRL_DRIFT_BIT];
    assign sense_range_select = ctrl_r[pmr_pkg::CTRL_RANGE_BIT];

    // Accumulators; a clear wins over a step arriving in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            energy_r <= 40'h00_0000_0000;
            charge_r <= 40'h00_0000_0000;
        end else if (soft_rst_r || (ctrl_wr && wr_data_r[pmr_pkg::CTRL_ACC_CLEAR_BIT])) begin
            energy_r <= 40'h00_0000_0000;
            charge_r <= 40'h00_0000_0000;
        end else if (acc_step) begin
            energy_r <= energy_r + energy_step;
            charge_r <= charge_r + charge_step;
        end
    end

    // Start delay, rearmed by any control write so new settings get a fresh wait
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dly_cnt_r <= '0;
            conv_en_r <= 1'b0;
        end else if (soft_rst_r) begin
            dly_cnt_r <= '0;
            conv_en_r <= 1'b0;
        end else if (ctrl_wr) begin
            dly_cnt_r <= pmr_pkg::DELAY_CNT_W'(wr_data_r[pmr_pkg::CTRL_DELAY_MSB:pmr_pkg::CTRL_DELAY_LSB])
                * pmr_pkg::DELAY_CNT_W'(DELAY_STEP_CYCLES);
            conv_en_r <= 1'b0;
        end else if (dly_cnt_r != '0) begin
            dly_cnt_r <= dly_cnt_r - pmr_pkg::DELAY_CNT_W'(1);
        end else begin
            conv_en_r <= 1'b1;
        end
    end

    assign conversion_enable = conv_en_r;

    // Plain read/write words; other offsets except control take no write
    generate
        for (genvar i = 0; i < pmr_pkg::NUM_RW; i++) begin : g_rw
            pmr_word_reg #(
                .RESET_VAL(pmr_pkg::RW_RESET[i])
            ) u_reg (
                .clock(clock),
                .rstn(rstn),
                .soft_rst(soft_rst_r),
                .wr_en(wr_en_r && ptr_r == pmr_pkg::RW_OFS[i]),
                .wr_data(wr_data_r),
                .q(rw_q[i])
            );
        end
    endgenerate

    assign converter_setup = rw_q[0];
    assign sense_resistor_scale = rw_q[1];
    assign sense_resistor_drift_coeff = rw_q[2];
    assign sense_over_threshold = rw_q[3];
    assign sense_under_threshold = rw_q[4];
    assign rail_over_threshold = rw_q[5];
    assign rail_under_threshold = rw_q[6];
    assign temperature_over_threshold = rw_q[7];
    assign power_over_threshold = rw_q[8];

endmodule

// ### pmr_pkg.sv
package pmr_pkg;

    // Register pointer offsets
    localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CONVERTER_SETUP = 8'h01;
    localparam logic [7:0] OFS_SENSE_RESISTOR_SCALE = 8'h02;
    localparam logic [7:0] OFS_SENSE_RESISTOR_DRIFT_COEFF = 8'h03;
    localparam logic [7:0] OFS_SENSE_VOLTAGE_RESULT = 8'h04;
    localparam logic [7:0] OFS_RAIL_VOLTAGE_RESULT = 8'h05;
    localparam logic [7:0] OFS_DIE_TEMPERATURE_RESULT = 8'h06;
    localparam logic [7:0] OFS_CURRENT_RESULT = 8'h07;
    localparam logic [7:0] OFS_POWER_RESULT = 8'h08;
    localparam logic [7:0] OFS_ENERGY_ACCUMULATOR = 8'h09;
    localparam logic [7:0] OFS_CHARGE_ACCUMULATOR = 8'h0a;
    localparam logic [7:0] OFS_DIAGNOSTIC_FLAGS_ALERT = 8'h0b;
    localparam logic [7:0] OFS_SENSE_OVER_THRESHOLD = 8'h0c;
    localparam logic [7:0] OFS_SENSE_UNDER_THRESHOLD = 8'h0d;
    localparam logic [7:0] OFS_RAIL_OVER_THRESHOLD = 8'h0e;
    localparam logic [7:0] OFS_RAIL_UNDER_THRESHOLD = 8'h0f;
    localparam logic [7:0] OFS_TEMPERATURE_OVER_THRESHOLD = 8'h10;
    localparam logic [7:0] OFS_POWER_OVER_THRESHOLD = 8'h11;
    localparam logic [7:0] OFS_MAKER_IDENTITY = 8'h3e;
    localparam logic [7:0] OFS_PART_IDENTITY = 8'h3f;

    // Control register fields
    localparam int CTRL_SOFT_RESET_BIT = 15;
    localparam int CTRL_ACC_CLEAR_BIT = 14;
    localparam int CTRL_DELAY_MSB = 13;
    localparam int CTRL_DELAY_LSB = 6;
    localparam int CTRL_DRIFT_BIT = 5;
    localparam int CTRL_RANGE_BIT = 4;
    localparam logic [15:0] CTRL_STORE_MASK = 16'h3ff0;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Plain 16-bit read/write registers, in instance order
    localparam int NUM_RW = 9;
    localparam logic [15:0] SETUP_RESET = 16'hfb68;
    localparam logic [15:0] PLAIN_RESET = 16'h0000;
    localparam logic [7:0] RW_OFS [NUM_RW] = '{
        OFS_CONVERTER_SETUP, OFS_SENSE_RESISTOR_SCALE, OFS_SENSE_RESISTOR_DRIFT_COEFF,
        OFS_SENSE_OVER_THRESHOLD, OFS_SENSE_UNDER_THRESHOLD, OFS_RAIL_OVER_THRESHOLD,
        OFS_RAIL_UNDER_THRESHOLD, OFS_TEMPERATURE_OVER_THRESHOLD, OFS_POWER_OVER_THRESHOLD};
    localparam logic [15:0] RW_RESET [NUM_RW] = '{
        SETUP_RESET, PLAIN_RESET, PLAIN_RESET, PLAIN_RESET, PLAIN_RESET,
        PLAIN_RESET, PLAIN_RESET, PLAIN_RESET, PLAIN_RESET};

    // Identity words, values are arbitrary
    localparam logic [15:0] MAKER_IDENTITY_VAL = 16'h5a5a;
    localparam logic [15:0] PART_IDENTITY_VAL = 16'h0a01;

    // Two-wire link
    localparam logic [6:0] LINK_ADDR_BASE = 7'h40;
    localparam int SHIFT_W = 40;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Start delay timing
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int DELAY_STEP_MS = 2;
    localparam int DELAY_STEP_CYCLES = DELAY_STEP_MS * 1_000_000 / CLOCK_PERIOD_NS;
    localparam int DELAY_CNT_W = 28;

    typedef enum logic [3:0] {
        PMR_IDLE = 4'b0000,
        PMR_ADDR = 4'b0001,
        PMR_ADDR_ACK = 4'b0010,
        PMR_PTR = 4'b0011,
        PMR_PTR_ACK = 4'b0100,
        PMR_WDATA = 4'b0101,
        PMR_WDATA_ACK = 4'b0110,
        PMR_RDATA = 4'b0111,
        PMR_RACK = 4'b1000
    } pmr_state_t;

endpackage

// ### pmr_word_reg.sv
`timescale 1ns/1ps
module pmr_word_reg #(
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    // Clock and resets
    input wire logic clock,
    input wire logic rstn,
    input wire logic soft_rst,
    // Write port
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    // Stored word
    output logic [15:0] q
);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            q <= RESET_VAL;
        end else if (soft_rst) begin
            q <= RESET_VAL;
        end else if (wr_en) begin
            q <= wr_data;
        end
    end

endmodule

// ### pmr_regs_sva.sv
`timescale 1ns/1ps
module pmr_regs_sva #(
    parameter int DELAY_STEP_CYCLES = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Link pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Configuration outputs
    input wire logic sense_drift_correction,
    input wire logic sense_range_select,
    input wire logic conversion_enable,
    input wire logic [15:0] converter_setup
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // Longest start delay plus slack for the write pulse and the rise
    localparam int MAX_LOW = 255 * DELAY_STEP_CYCLES + 3;
    int low_cnt_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            low_cnt_r <= 0;
        end else if (conversion_enable) begin
            low_cnt_r <= 0;
        end else begin
            low_cnt_r <= low_cnt_r + 1;
        end
    end

    sequence start_seen;
        scl_in && $fell(sda_in);
    endsequence
    sequence host_owns_addr;
        !sda_oe [*8];
    endsequence

    drive_open_a: assert property (sda_out == 1'b0) else $error("Data pin driven high");
    setup_reset_a: assert property ($rose(rstn) |-> converter_setup == 16'hfb68) else $error("Setup reset value");
    ctrl_reset_a: assert property ($rose(rstn) |-> !sense_drift_correction && !sense_range_select)
        else $error("Control reset value");
    conv_start_a: assert property ($rose(rstn) |-> ##[1:2] conversion_enable) else $error("No start after reset");
    sda_change_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("Data changed while clock high");
    cfg_change_a: assert property ($changed({sense_drift_correction, sense_range_select}) |-> !scl_in)
        else $error("Control changed outside write");
    delay_drop_a: assert property ($fell(conversion_enable) |-> !scl_in) else $error("Delay restarted outside write");
    delay_bound_a: assert property (low_cnt_r <= MAX_LOW) else $error("Start delay too long");
    addr_quiet_a: assert property (start_seen |-> ##1 host_owns_addr) else $error("Driven during address");
endmodule

bind pmr_power_monitor_regs pmr_regs_sva #(.DELAY_STEP_CYCLES(DELAY_STEP_CYCLES)) i_sva (
    .clock(clock), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .sense_drift_correction(sense_drift_correction), .sense_range_select(sense_range_select),
    .conversion_enable(conversion_enable), .converter_setup(converter_setup));

// ### pmr_host_model.sv
`timescale 1ns/1ps
module pmr_host_model (
    // Clock
    input wire logic clock,
    // Link wires
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Data moves only mid low phase; line sampled late in the high phase
    task automatic bit_io(input logic b, output logic s);
        scl = 1'b0;
        wait_clk(3);
        sda = b;
        wait_clk(3);
        scl = 1'b1;
        wait_clk(4);
        s = sda_line;
    endtask

    task automatic start_cond();
        scl = 1'b1;
        wait_clk(4);
        sda = 1'b0;
        wait_clk(4);
    endtask

    task automatic stop_cond();
        scl = 1'b0;
        wait_clk(3);
        sda = 1'b0;
        wait_clk(3);
        scl = 1'b1;
        wait_clk(4);
        sda = 1'b1;
        wait_clk(4);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // Pointer byte always follows the address byte of a write
    task automatic write_word(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] d,
                              input logic with_data, output logic ok);
        logic a0, a1, a2, a3;
        a2 = 1'b1;
        a3 = 1'b1;
        start_cond();
        send_byte({dev, 1'b0}, a0);
        send_byte(ptr, a1);
        if (with_data) begin
            send_byte(d[15:8], a2);
            send_byte(d[7:0], a3);
        end
        stop_cond();
        ok = a0 & a1 & a2 & a3;
    endtask

    // Last byte gets a NACK so the device lets go of the line
    task automatic read_bytes(input logic [6:0] dev, input int n, output logic [39:0] v, output logic ok);
        logic s;
        logic [7:0] b;
        v = '0;
        start_cond();
        send_byte({dev, 1'b1}, ok);
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 8; i++) begin
                bit_io(1'b1, s);
                b = {b[6:0], s};
            end
            bit_io(k == n - 1, s);
            v = {v[31:0], b};
        end
        stop_cond();
    endtask
endmodule

// ### pmr_power_monitor_regs_tb.sv
`timescale 1ns/1ps
module pmr_power_monitor_regs_tb;
    localparam int STEP = 4;
    localparam logic [15:0] MAKER = 16'h1357;
    localparam logic [15:0] PART = 16'h2468;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic scl, sda_host, sda_line, sda_out, sda_oe, drift, range, conv_en;
    logic acc_step = 1'b0;
    logic [3:0] addr_pin_code = 4'h6;
    logic [6:0] dev = 7'h46;
    logic [23:0] sv_m = 24'h12_3456, rv_m = 24'h65_4321, cur_m = 24'h00_1111, pw_m = 24'h22_0000;
    logic [15:0] dt_m = 16'h0abc, dg_m = 16'h0041;
    logic [39:0] e_step = 40'h01_2345_6789, c_step = 40'h00_0000_0101;
    logic [15:0] cfg [9];
    int fails = 0, total_checks = 0, low_run = 0, last_low = 0;

    assign sda_line = sda_host & ~sda_oe;
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        if (!conv_en) begin
            low_run <= low_run + 1;
        end else if (low_run != 0) begin
            last_low <= low_run;
            low_run <= 0;
        end
    end

    pmr_host_model i_host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda(sda_host));
    pmr_power_monitor_regs #(.DELAY_STEP_CYCLES(STEP), .MAKER_IDENTITY(MAKER), .PART_IDENTITY(PART)) i_dut (
        .clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_pin_code(addr_pin_code), .sense_voltage_meas(sv_m), .rail_voltage_meas(rv_m),
        .die_temperature_meas(dt_m), .current_meas(cur_m), .power_meas(pw_m), .diag_flags_meas(dg_m),
        .acc_step(acc_step), .energy_step(e_step), .charge_step(c_step), .sense_drift_correction(drift),
        .sense_range_select(range), .conversion_enable(conv_en), .converter_setup(cfg[0]),
        .sense_resistor_scale(cfg[1]), .sense_resistor_drift_coeff(cfg[2]), .sense_over_threshold(cfg[3]),
        .sense_under_threshold(cfg[4]), .rail_over_threshold(cfg[5]), .rail_under_threshold(cfg[6]),
        .temperature_over_threshold(cfg[7]), .power_over_threshold(cfg[8]));

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        logic ok;
        i_host.write_word(dev, p, d, 1'b1, ok);
        chk({39'h0, ok}, 40'h1);
    endtask

    // Pointer-only write, then a read of n bytes
    task automatic rd(input logic [7:0] p, input int n, input logic [39:0] e);
        logic ok;
        logic [39:0] v;
        i_host.write_word(dev, p, 16'h0000, 1'b0, ok);
        i_host.read_bytes(dev, n, v, ok);
        chk(v, e);
    endtask

    task automatic t_reset_values();
        rd(8'h00, 2, '0);
        rd(8'h01, 2, 40'h00_0000_fb68);
        chk({24'h0, cfg[0]}, 40'h00_0000_fb68);
    endtask

    task automatic t_ctrl_fields();
        wr(8'h00, 16'h003f);
        rd(8'h00, 2, 40'h00_0000_0030);
        chk({38'h0, drift, range}, 40'h3);
        wr(8'h00, 16'h0010);
        chk({38'h0, drift, range}, 40'h1);
        wr(8'h00, 16'h0020);
        chk({38'h0, drift, range}, 40'h2);
    endtask

    task automatic t_delay(input logic [7:0] code);
        wr(8'h00, {2'b00, code, 6'h00});
        for (int i = 0; i < 1100 && conv_en !== 1'b1; i++) i_host.wait_clk(1);
        // The run length latches one edge after the rise
        i_host.wait_clk(1);
        chk({39'h0, conv_en}, 40'h1);
        chk({39'h0, last_low >= code * STEP && last_low <= code * STEP + 2}, 40'h1);
        rd(8'h00, 2, {24'h0, 2'b00, code, 6'h00});
    endtask

    task automatic t_acc();
        repeat (2) begin
            acc_step = 1'b1;
            i_host.wait_clk(1);
            acc_step = 1'b0;
            i_host.wait_clk(1);
        end
        rd(8'h09, 5, 40'h02_468a_cf12);
        rd(8'h0a, 5, 40'h00_0000_0202);
        wr(8'h00, 16'h4000);
        rd(8'h09, 5, '0);
        rd(8'h0a, 5, '0);
        rd(8'h00, 2, '0);
    endtask

    task automatic t_readonly();
        {sv_m, rv_m} = {rv_m, sv_m};
        {cur_m, pw_m} = {pw_m, cur_m};
        {dt_m, dg_m} = {dg_m, dt_m};
        wr(8'h05, 16'hffff);
        rd(8'h05, 3, {16'h0, rv_m});
        rd(8'h04, 3, {16'h0, sv_m});
        rd(8'h06, 3, {16'h0, dt_m, 8'h00});
        rd(8'h07, 3, {16'h0, cur_m});
        rd(8'h08, 3, {16'h0, pw_m});
        rd(8'h0b, 2, {24'h0, dg_m});
        wr(8'h3e, 16'h0000);
        rd(8'h3e, 2, {24'h0, MAKER});
        rd(8'h3f, 2, {24'h0, PART});
    endtask

    task automatic t_ptr_keep();
        logic ok;
        logic [39:0] v;
        wr(8'h02, 16'hbeef);
        rd(8'h02, 2, 40'h00_0000_beef);
        i_host.read_bytes(dev, 2, v, ok);
        chk(v, 40'h00_0000_beef);
    endtask

    // Only mapped offsets are written
    task automatic t_rw_table();
        for (int i = 0; i < pmr_pkg::NUM_RW; i++) begin
            wr(pmr_pkg::RW_OFS[i], 16'ha5c0 + 16'(i));
            rd(pmr_pkg::RW_OFS[i], 2, {24'h0, 16'ha5c0 + 16'(i)});
            chk({24'h0, cfg[i]}, {24'h0, 16'ha5c0 + 16'(i)});
        end
    endtask

    task automatic t_soft_reset();
        wr(8'h00, 16'h0030);
        wr(8'h00, 16'h8000);
        i_host.wait_clk(2);
        chk({38'h0, drift, range}, '0);
        chk({24'h0, cfg[0]}, 40'h00_0000_fb68);
        chk({24'h0, cfg[8]}, '0);
        rd(8'h00, 2, '0);
    endtask

    task automatic t_address();
        logic ok;
        i_host.write_word(dev ^ 7'h01, 8'h00, 16'h0030, 1'b1, ok);
        chk({39'h0, ok}, '0);
        chk({38'h0, drift, range}, '0);
        addr_pin_code = 4'h9;
        dev = 7'h49;
        i_host.wait_clk(2);
        rd(8'h3f, 2, {24'h0, PART});
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clock);
        #1 rstn = 1'b1;
        i_host.wait_clk(4);
        t_reset_values();
        t_ctrl_fields();
        t_delay(8'h03);
        t_delay(8'hff);
        t_acc();
        t_readonly();
        t_ptr_keep();
        t_rw_table();
        t_soft_reset();
        t_address();
        tally_and_finish();
    end

    // Traffic needs roughly 26k cycles; 60k, over twice that, means a hang
    initial begin
        #(60_000 * 5);
        fails++;
        tally_and_finish();
    end
endmodule
